// [logic/dmfs_far.sv]
`timescale 1ns/1ps
`default_nettype none
module dmfs_far (
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	dmfs_link_if.far        link,
	input  wire logic       i_main_start,
	input  wire logic       i_main_page_fault,
	input  wire logic       i_main_genuine_error,
	input  wire logic       i_dma_req,
	output var  logic       o_main_done,
	output var  logic       o_main_berr,
	output var  logic       o_fixer_busy
);
	import dmfs_pkg::*;

	// ****************************************
	// state
	// ****************************************
	dmfs_far_t st_reg;
	dmfs_far_t st_next;

	// ****************************************
	// processors, mmu and memory
	// ****************************************
	// the fixer only ever touches the switch location; page work itself is left out
	always_comb
	begin
		st_next           = st_reg;
		st_next.main_done = 1'b0;
		st_next.main_berr = 1'b0;

		// main cpu bus cycle
		case (st_reg.main_st)
			M_IDLE:
			if (i_main_start)
			begin
				st_next.main_as_n = 1'b0;
				st_next.bad       = i_main_page_fault || i_main_genuine_error;
				st_next.err       = i_main_genuine_error;
				st_next.main_st   = M_WAIT;
			end
			M_WAIT:
			if (!link.forced_bus_error_n || !link.watchdog_berr_n)
			begin
				st_next.main_as_n = 1'b1;
				st_next.main_berr = 1'b1;
				st_next.bad       = 1'b0;
				st_next.main_st   = M_END;
			end
			else if (!link.main_cpu_ack_n)
			begin
				st_next.main_as_n = 1'b1;
				st_next.main_done = 1'b1;
				st_next.main_st   = M_END;
			end
			M_END:
				st_next.main_st = M_IDLE;
			default:
				st_next.main_st = M_IDLE;
		endcase

		// mmu: a bad translation faults and never maps the strobe
		if (!link.system_addr_strobe_n && !link.owner_select && st_reg.bad)
			st_next.fault_n = 1'b0;
		st_next.mas_n = link.system_addr_strobe_n || (st_reg.bad && !link.owner_select); // [R15]
		// memory acknowledges a mapped strobe one clock later
		st_next.sys_ack_n = st_reg.mas_n || link.system_addr_strobe_n;

		// dma only while no main cycle can fault
		st_next.dma_br_n = !(i_dma_req && st_reg.main_st == M_IDLE);              // [R22]

		// second cpu handler
		case (st_reg.fix_st)
			F_HOLD:
			if (link.second_cpu_hold_request_n)
			begin
				// fault line lifts as soon as the handler is released, so its
				// two-stage sync has cleared before the switch write is seen
				st_next.fault_n    = 1'b1;                                        // [R17]
				st_next.lead_cnt   = 2'h1;
				st_next.fix_st     = F_LEAD;
				st_next.fixer_busy = 1'b1;
			end
			F_LEAD:
			if (st_reg.lead_cnt == FIX_LEAD_CYCLES)
			begin
				// page fix assumed done here; handler goes straight to the switch
				st_next.second_as_n = 1'b0;                                       // [R16]
				st_next.switch_sel  = 1'b1;
				st_next.second_rw   = st_reg.err;                                 // [R19]
				st_next.fix_st      = st_reg.err ? F_READ : F_WRITE;
			end
			else
				st_next.lead_cnt = st_reg.lead_cnt + 2'h1;
			F_READ:
			if (!link.switch_ack_n)
			begin
				// indivisible: strobe held, only direction turns
				st_next.second_rw = 1'b0;                                         // [R19]
				st_next.err       = 1'b0;
				st_next.fix_st    = F_WRITE;
			end
			F_WRITE:
			if (!link.switch_ack_n)
			begin
				st_next.second_as_n = 1'b1;
				st_next.switch_sel  = 1'b0;
				st_next.second_rw   = 1'b1;
				st_next.bad         = st_reg.err ? st_reg.bad : 1'b0;
				st_next.fix_st      = F_RELEASE;
			end
			F_RELEASE:
			if (!link.second_cpu_hold_request_n)
			begin
				st_next.fixer_busy = 1'b0;
				st_next.fix_st     = F_HOLD;
			end
			default:
				st_next.fix_st = F_HOLD;
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st_reg <= FAR_RESET;
		else
			st_reg <= st_next;
	end

	// ****************************************
	// outputs
	// ****************************************
	// grants: bus owners grant whenever dma asks; no real arbitration modelled
	assign link.main_cpu_addr_strobe_n   = st_reg.main_as_n;
	assign link.second_cpu_addr_strobe_n = st_reg.second_as_n;
	assign link.second_rw                = st_reg.second_rw;
	assign link.switch_sel               = st_reg.switch_sel;
	assign link.unpop_sel                = 1'b0;
	assign link.mapped_addr_strobe_n     = st_reg.mas_n;
	assign link.system_ack_n             = st_reg.sys_ack_n;
	assign link.fault_n                  = st_reg.fault_n;
	assign link.dma_br_n                 = st_reg.dma_br_n;
	assign link.main_bg_n                = st_reg.dma_br_n;
	assign link.second_bg_n              = st_reg.dma_br_n;
	assign link.dma_bgack_n              = st_reg.dma_br_n;
	assign o_main_done                   = st_reg.main_done;
	assign o_main_berr                   = st_reg.main_berr;
	assign o_fixer_busy                  = st_reg.fixer_busy;

endmodule : dmfs_far
`default_nettype wire

// [logic/dmfs_pkg.sv]
//
// Overview of operation
// (R1) owner select low enables main buffers
// (R2) system strobe follows selected processor strobe
// (R3) strobe select follows owner select later
// (R4) dma handshake steered to bus owner
// (R5) second cpu switch read forces error
// (R6) null location $1f write holds second cpu
// (R7) switch location read raises main bus error
// (R8) switch access acknowledged by this logic
// (R9) watchdog ends accesses nobody acknowledges
// (R10) reset gives second processor the bus
// (R11) switch write asserts hold request
// (R12) end of switch write hands bus over
// (R13) strobe select falls two clocks later
// (R14) fault returns bus to second processor
// (R15) mmu withholds mapped strobe on fault
// (R16) second cpu starts three clocks after release
// (R17) handler writes dirty page before reload; the far-end fixer does no page work and goes straight to the switch access (read then write on a genuine error)
// (R18) forced error ends with main strobe
// (R19) genuine error uses read-modify-write on switch
// (R20) suspended main strobe resumes after switch
// (R21) owner or dma grant picks upper space
// (R22) dma stays idle while faults possible
// (R23) main acknowledge rests negated when detached
// (R24) asynchronous inputs synchronized before use; system acknowledge is also read raw for main ack and watchdog
`default_nettype none
package dmfs_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned WDOG_TIME_NS    = 2000;
	localparam int unsigned WDOG_CYCLES     = (WDOG_TIME_NS / CLK_PERIOD_NS);
	localparam int unsigned WDOG_W          = 8;
	localparam logic [WDOG_W-1:0] WDOG_LIMIT = WDOG_W'(WDOG_CYCLES);
	localparam logic [7:0]  SWITCH_LOC      = 8'h1f;
	localparam logic [1:0]  FIX_LEAD_CYCLES = 2'h3;

	// ****************************************
	// control logic state
	// ****************************************
	typedef struct packed {
		logic [1:0]        fault_sync;
		logic [1:0]        mas_sync;
		logic [1:0]        ack_sync;
		logic              hold_n;
		logic              owner;
		logic              ss_early;
		logic              ss;
		logic              switch_pend;
		logic              berr_n;
		logic              sw_ack_n;
		logic              wd_berr_n;
		logic [WDOG_W-1:0] wd_cnt;
		logic              as_sys_n;
		logic              main_ack_n;
		logic              main_br_n;
		logic              second_br_n;
		logic              dma_bg_n;
		logic              main_bgack_n;
		logic              second_bgack_n;
		logic              upper_space;
	} dmfs_ctl_t;

	localparam dmfs_ctl_t CTL_RESET = '{
		fault_sync: 2'h3, mas_sync: 2'h3, ack_sync: 2'h3,
		hold_n: 1'b1, owner: 1'b1, ss_early: 1'b1, ss: 1'b1,
		switch_pend: 1'b0, berr_n: 1'b1, sw_ack_n: 1'b1, wd_berr_n: 1'b1,
		wd_cnt: '0, as_sys_n: 1'b1, main_ack_n: 1'b1, main_br_n: 1'b1,
		second_br_n: 1'b1, dma_bg_n: 1'b1, main_bgack_n: 1'b1,
		second_bgack_n: 1'b1, upper_space: 1'b1};

	// ****************************************
	// far end (processors, mmu, memory)
	// ****************************************
	typedef enum logic [1:0] {M_IDLE, M_WAIT, M_END} dmfs_main_t;
	typedef enum logic [2:0] {F_HOLD, F_LEAD, F_READ, F_WRITE, F_RELEASE} dmfs_fix_t;

	typedef struct packed {
		dmfs_main_t main_st;
		dmfs_fix_t  fix_st;
		logic [1:0] lead_cnt;
		logic       bad;
		logic       err;
		logic       main_as_n;
		logic       second_as_n;
		logic       second_rw;
		logic       switch_sel;
		logic       mas_n;
		logic       sys_ack_n;
		logic       fault_n;
		logic       dma_br_n;
		logic       main_done;
		logic       main_berr;
		logic       fixer_busy;
	} dmfs_far_t;

	localparam dmfs_far_t FAR_RESET = '{
		main_st: M_IDLE, fix_st: F_HOLD, lead_cnt: 2'h0, bad: 1'b0, err: 1'b0,
		main_as_n: 1'b1, second_as_n: 1'b1, second_rw: 1'b1, switch_sel: 1'b0,
		mas_n: 1'b1, sys_ack_n: 1'b1, fault_n: 1'b1, dma_br_n: 1'b1,
		main_done: 1'b0, main_berr: 1'b0, fixer_busy: 1'b0};

endpackage : dmfs_pkg
`default_nettype wire

// [logic/dmfs_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dmfs_link_if;
	// far end to control logic
	logic main_cpu_addr_strobe_n;
	logic second_cpu_addr_strobe_n;
	logic second_rw;
	logic switch_sel;
	logic unpop_sel;
	logic mapped_addr_strobe_n;
	logic system_ack_n;
	logic fault_n;
	logic dma_br_n;
	logic main_bg_n;
	logic second_bg_n;
	logic dma_bgack_n;
	// control logic to far end
	logic main_buf_en_n;
	logic owner_select;
	logic strobe_source_select;
	logic system_addr_strobe_n;
	logic second_cpu_hold_request_n;
	logic forced_bus_error_n;
	logic main_cpu_ack_n;
	logic switch_ack_n;
	logic watchdog_berr_n;
	logic main_br_n;
	logic second_br_n;
	logic dma_bg_n;
	logic main_bgack_n;
	logic second_bgack_n;
	logic upper_space;

	modport ctl (
		input  main_cpu_addr_strobe_n, second_cpu_addr_strobe_n, second_rw, switch_sel, unpop_sel,
		input  mapped_addr_strobe_n, system_ack_n, fault_n, dma_br_n, main_bg_n, second_bg_n,
		input  dma_bgack_n,
		output main_buf_en_n, owner_select, strobe_source_select, system_addr_strobe_n,
		output second_cpu_hold_request_n, forced_bus_error_n, main_cpu_ack_n, switch_ack_n,
		output watchdog_berr_n, main_br_n, second_br_n, dma_bg_n, main_bgack_n, second_bgack_n,
		output upper_space
	);

	modport far (
		output main_cpu_addr_strobe_n, second_cpu_addr_strobe_n, second_rw, switch_sel, unpop_sel,
		output mapped_addr_strobe_n, system_ack_n, fault_n, dma_br_n, main_bg_n, second_bg_n,
		output dma_bgack_n,
		input  main_buf_en_n, owner_select, strobe_source_select, system_addr_strobe_n,
		input  second_cpu_hold_request_n, forced_bus_error_n, main_cpu_ack_n, switch_ack_n,
		input  watchdog_berr_n, main_br_n, second_br_n, dma_bg_n, main_bgack_n, second_bgack_n,
		input  upper_space
	);
endinterface : dmfs_link_if
`default_nettype wire

// [logic/dmfs_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
module dmfs_ctl (
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	dmfs_link_if.ctl        link,
	output var  logic       o_second_owns,
	output var  logic       o_bus_error_active
);
	import dmfs_pkg::*;

	// ****************************************
	// state
	// ****************************************
	dmfs_ctl_t st_reg;
	dmfs_ctl_t st_next;

	// ****************************************
	// next-state logic
	// ****************************************
	// one struct keeps ownership, strobe select, error and watchdog state together
	always_comb
	begin
		logic sw_access;
		logic sw_write;
		logic sw_read;
		logic fault_now;
		logic switch_end;
		logic ss_pick;
		sw_access = 1'b0;
		sw_write  = 1'b0;
		sw_read   = 1'b0;
		fault_now = 1'b0;
		switch_end = 1'b0;
		ss_pick   = 1'b0;
		st_next   = st_reg;

		// two-stage synchronizers, only stage one reads the pin
		st_next.fault_sync = {st_reg.fault_sync[0], link.fault_n};              // [R24]
		st_next.mas_sync   = {st_reg.mas_sync[0], link.mapped_addr_strobe_n};   // [R24]
		st_next.ack_sync   = {st_reg.ack_sync[0], link.system_ack_n};           // [R24]

		// switch location decode; only the second cpu can reach it while it owns the bus
		sw_access = st_reg.owner && !link.second_cpu_addr_strobe_n && link.switch_sel;
		sw_write  = sw_access && !link.second_rw;
		sw_read   = sw_access && link.second_rw;
		fault_now = !st_reg.fault_sync[1];

		// switch write clears the request flop: hold the second cpu off
		if (sw_write)
		begin
			st_next.hold_n      = 1'b0;                                         // [R6] [R11]
			st_next.switch_pend = 1'b1;
		end

		// owner flop clocks low once strobe and acknowledge of the switch write negate
		switch_end = st_reg.switch_pend && !sw_access && st_reg.mas_sync[1] && st_reg.ack_sync[1];
		if (switch_end)
		begin
			st_next.owner       = 1'b0;                                         // [R12]
			st_next.switch_pend = 1'b0;
		end

		// fault presets both flops; it outranks a pending switch
		if (fault_now)
		begin
			st_next.hold_n      = 1'b1;                                         // [R14]
			st_next.owner       = 1'b1;                                         // [R14]
			st_next.switch_pend = 1'b0;
		end

		// strobe select: preset while owner high, else falls after two edges
		if (st_next.owner)
		begin
			st_next.ss_early = 1'b1;                                            // [R3]
			st_next.ss       = 1'b1;
		end
		else
		begin
			// early stage trails owner by one edge, so the select drops on the second edge
			st_next.ss_early = st_reg.owner;                                    // [R13]
			st_next.ss       = st_reg.ss_early;                                 // [R3] [R13]
		end

		// strobe multiplexer; the suspended main strobe passes once select drops
		ss_pick = st_next.ss;
		st_next.as_sys_n = ss_pick ? link.second_cpu_addr_strobe_n
		                           : link.main_cpu_addr_strobe_n;               // [R2] [R20]

		// main acknowledge blocked while detached, as if pulled up
		st_next.main_ack_n = st_next.owner ? 1'b1 : link.system_ack_n;          // [R23] [R14]

		// forced bus error flop: set by switch read, preset by main strobe negation
		if (sw_read)
			st_next.berr_n = 1'b0;                                              // [R5] [R7] [R18]
		else if (link.main_cpu_addr_strobe_n)
			st_next.berr_n = 1'b1;                                              // [R18]

		// switch location answers itself since no timer part is assumed
		st_next.sw_ack_n = !sw_access;                                          // [R8]

		// watchdog: a strobe with no acknowledge for too long gets a bus error
		if (st_reg.as_sys_n)
		begin
			st_next.wd_cnt    = '0;
			st_next.wd_berr_n = 1'b1;
		end
		else if (!link.system_ack_n || !st_reg.sw_ack_n)
			st_next.wd_cnt = '0;
		else if (st_reg.wd_cnt == WDOG_LIMIT)
			st_next.wd_berr_n = 1'b0;                                           // [R9]
		else
			st_next.wd_cnt = st_reg.wd_cnt + 1'b1;                              // [R9]

		// dma handshake follows the owner
		st_next.main_br_n      = st_next.owner ? 1'b1 : link.dma_br_n;          // [R4]
		st_next.second_br_n    = st_next.owner ? link.dma_br_n : 1'b1;          // [R4]
		st_next.dma_bg_n       = st_next.owner ? link.second_bg_n : link.main_bg_n; // [R4]
		st_next.main_bgack_n   = st_next.owner ? 1'b1 : link.dma_bgack_n;       // [R4]
		st_next.second_bgack_n = st_next.owner ? link.dma_bgack_n : 1'b1;       // [R4]

		// upper address-space group for second cpu or dma
		st_next.upper_space = st_next.owner || !link.dma_bgack_n;               // [R21]
	end

	// ****************************************
	// registers
	// ****************************************
	// reset sets both ownership flops: second cpu released and in charge
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st_reg <= CTL_RESET;                                                // [R10]
		else
			st_reg <= st_next;
	end

	// ****************************************
	// outputs
	// ****************************************
	// all straight from the state flops
	assign link.main_buf_en_n             = st_reg.owner;                       // [R1]
	assign link.owner_select              = st_reg.owner;
	assign link.strobe_source_select      = st_reg.ss;
	assign link.system_addr_strobe_n      = st_reg.as_sys_n;
	assign link.second_cpu_hold_request_n = st_reg.hold_n;
	assign link.forced_bus_error_n        = st_reg.berr_n;
	assign link.main_cpu_ack_n            = st_reg.main_ack_n;
	assign link.switch_ack_n              = st_reg.sw_ack_n;
	assign link.watchdog_berr_n           = st_reg.wd_berr_n;
	assign link.main_br_n                 = st_reg.main_br_n;
	assign link.second_br_n               = st_reg.second_br_n;
	assign link.dma_bg_n                  = st_reg.dma_bg_n;
	assign link.main_bgack_n              = st_reg.main_bgack_n;
	assign link.second_bgack_n            = st_reg.second_bgack_n;
	assign link.upper_space               = st_reg.upper_space;
	assign o_second_owns                  = st_reg.owner;
	assign o_bus_error_active             = !st_reg.berr_n;

endmodule : dmfs_ctl
`default_nettype wire

// [tb/dmfs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module dmfs_assertions (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic main_cpu_addr_strobe_n,
	input wire logic second_cpu_addr_strobe_n,
	input wire logic second_rw,
	input wire logic switch_sel,
	input wire logic system_ack_n,
	input wire logic fault_n,
	input wire logic dma_br_n,
	input wire logic main_buf_en_n,
	input wire logic owner_select,
	input wire logic strobe_source_select,
	input wire logic system_addr_strobe_n,
	input wire logic second_cpu_hold_request_n,
	input wire logic forced_bus_error_n,
	input wire logic main_cpu_ack_n,
	input wire logic switch_ack_n,
	input wire logic main_br_n,
	input wire logic second_br_n
);
	// ****************************************
	// sequences
	// ****************************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);

	// switch location cycles of the second cpu
	sequence sw_write_s;
		owner_select && !second_cpu_addr_strobe_n && switch_sel && !second_rw;
	endsequence
	sequence sw_read_s;
		owner_select && !second_cpu_addr_strobe_n && switch_sel && second_rw;
	endsequence
	// fault has to outlast both sync stages before it counts
	sequence fault_s;
		!fault_n [*3];
	endsequence
	// select holds two samples so the mmu sees a settled address
	sequence ss_lag_s;
		strobe_source_select ##1 strobe_source_select ##1 !strobe_source_select;
	endsequence

	// ****************************************
	// properties
	// ****************************************
	buf_follow_a : assert property (main_buf_en_n == owner_select)
		else $error("main buffer enable differs from owner select");
	strobe_mux_a : assert property (system_addr_strobe_n == (strobe_source_select ?
		$past(second_cpu_addr_strobe_n) : $past(main_cpu_addr_strobe_n))) else $error("system strobe wrong source");
	ss_lag_a : assert property ($fell(owner_select) |-> ss_lag_s)
		else $error("strobe select did not lag owner select");
	hold_write_a : assert property (sw_write_s |=> !second_cpu_hold_request_n && !switch_ack_n)
		else $error("switch write missed hold or ack");
	read_berr_a : assert property (sw_read_s |=> !forced_bus_error_n && !switch_ack_n)
		else $error("switch read missed forced error");
	berr_clear_a : assert property (!forced_bus_error_n && main_cpu_addr_strobe_n &&
		!(owner_select && !second_cpu_addr_strobe_n && switch_sel && second_rw) |=> forced_bus_error_n)
		else $error("forced error outlived main strobe");
	fault_take_a : assert property (fault_s |=> owner_select && second_cpu_hold_request_n &&
		strobe_source_select && main_cpu_ack_n) else $error("fault did not return bus");
	main_ack_a : assert property (main_cpu_ack_n == (owner_select || $past(system_ack_n)))
		else $error("main ack wrong");
	dma_steer_a : assert property (main_br_n == (owner_select || $past(dma_br_n)) &&
		second_br_n == (!owner_select || $past(dma_br_n))) else $error("dma request steered wrong");
endmodule : dmfs_assertions
`default_nettype wire

// [tb/test_dual_master_fault_switch.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_master_fault_switch;
	localparam int LIM = 400;
	logic i_sys_clk;
	logic i_resetn;
	logic main_start;
	logic page_fault;
	logic genuine_error;
	logic dma_req;
	logic main_done;
	logic main_berr;
	logic fixer_busy;
	logic second_owns;
	logic bus_err_active;
	logic saw_second;
	logic saw_ferr;
	logic saw_berr;
	logic saw_done;
	int   fails;
	int   checked;

	// ****************************************
	// both ends and the checker
	// ****************************************
	dmfs_link_if link ();
	dmfs_ctl dmfs_ctl_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .link(link),
		.o_second_owns(second_owns), .o_bus_error_active(bus_err_active));
	dmfs_far dmfs_far_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .link(link), .i_main_start(main_start),
		.i_main_page_fault(page_fault), .i_main_genuine_error(genuine_error), .i_dma_req(dma_req),
		.o_main_done(main_done), .o_main_berr(main_berr), .o_fixer_busy(fixer_busy));
	dmfs_assertions dmfs_assertions_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.main_cpu_addr_strobe_n(link.main_cpu_addr_strobe_n), .second_cpu_addr_strobe_n(link.second_cpu_addr_strobe_n),
		.second_rw(link.second_rw), .switch_sel(link.switch_sel), .system_ack_n(link.system_ack_n),
		.fault_n(link.fault_n), .dma_br_n(link.dma_br_n), .main_buf_en_n(link.main_buf_en_n),
		.owner_select(link.owner_select), .strobe_source_select(link.strobe_source_select),
		.system_addr_strobe_n(link.system_addr_strobe_n), .second_cpu_hold_request_n(link.second_cpu_hold_request_n),
		.forced_bus_error_n(link.forced_bus_error_n), .main_cpu_ack_n(link.main_cpu_ack_n),
		.switch_ack_n(link.switch_ack_n), .main_br_n(link.main_br_n), .second_br_n(link.second_br_n));

	// free running 25 mhz clock
	initial
	begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	// ****************************************
	// helpers
	// ****************************************
	// drive just after the edge so no race with the design
	task automatic step();
		@(posedge i_sys_clk);
		#1;
	endtask : step
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1)
		begin
			$display("ERROR %0t: %s", $time, msg);
			fails++;
		end
	endtask : chk
	task automatic stop_test();
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic give_up(input int n);
		if (n >= LIM)
		begin
			$display("ERROR %0t: wait bound used up", $time);
			fails++;
			stop_test();
		end
	endtask : give_up
	// one main access; returns once the bus is back with the main cpu and idle
	task automatic run_main(input logic pf, input logic ge);
		int n;
		saw_second = 1'b0;
		saw_ferr = 1'b0;
		saw_berr = 1'b0;
		saw_done = 1'b0;
		page_fault = pf;
		genuine_error = ge;
		main_start = 1'b1;
		step();
		main_start = 1'b0;
		for (n = 0; n < LIM && !(saw_done || saw_berr); n++)
		begin
			step();
			saw_second |= second_owns;
			saw_ferr |= (link.forced_bus_error_n === 1'b0) && (bus_err_active === 1'b1);
			saw_berr |= main_berr;
			saw_done |= main_done;
		end
		give_up(n);
		for (n = 0; n < LIM && (fixer_busy !== 1'b0 || link.owner_select !== 1'b0); n++)
			step();
		give_up(n);
		repeat (20) step();
	endtask : run_main

	// ****************************************
	// scenarios
	// ****************************************
	// reset, then the fixer's first switch write hands the bus over
	task automatic t_reset(input int cycles);
		int n;
		i_resetn = 1'b0;
		repeat (cycles) step();
		chk(link.owner_select === 1'b1 && link.main_buf_en_n === 1'b1, "second cpu not owner in reset");
		chk(link.strobe_source_select === 1'b1 && link.second_cpu_hold_request_n === 1'b1, "reset state");
		i_resetn = 1'b1;
		for (n = 0; n < LIM && link.owner_select !== 1'b0; n++)
			step();
		give_up(n);
		chk(link.second_cpu_hold_request_n === 1'b0, "switch write left hold off");
		chk(link.main_buf_en_n === 1'b0 && second_owns === 1'b0, "main buffers not enabled");
		chk(link.upper_space === 1'b0, "main cpu in upper space");
		chk(link.strobe_source_select === 1'b1, "strobe select fell early");
		step();
		chk(link.strobe_source_select === 1'b1, "strobe select fell after one edge");
		step();
		chk(link.strobe_source_select === 1'b0, "strobe select late");
	endtask : t_reset
	task automatic t_normal();
		run_main(1'b0, 1'b0);
		chk(saw_done && !saw_second && !saw_berr, "plain access disturbed");
	endtask : t_normal
	// two faults back to back
	task automatic t_page_fault();
		repeat (2)
		begin
			run_main(1'b1, 1'b0);
			chk(saw_second, "fault kept bus with main cpu");
			chk(saw_done && !saw_berr, "suspended access lost");
			chk(link.strobe_source_select === 1'b0, "strobe not back on main");
		end
	endtask : t_page_fault
	task automatic t_genuine();
		run_main(1'b0, 1'b1);
		chk(saw_ferr, "switch read forced no error");
		chk(saw_berr, "main cpu saw no bus error");
		chk(link.forced_bus_error_n === 1'b1 && bus_err_active === 1'b0, "forced error stuck");
	endtask : t_genuine
	task automatic t_dma();
		int n;
		dma_req = 1'b1; // only while idle, no fault can race it
		for (n = 0; n < LIM && link.main_br_n !== 1'b0; n++)
			step();
		give_up(n);
		chk(link.second_br_n === 1'b1 && link.owner_select === 1'b0, "dma request to wrong cpu");
		dma_req = 1'b0;
		for (n = 0; n < LIM && link.main_br_n !== 1'b1; n++)
			step();
		give_up(n);
		repeat (8) step();
		chk(link.dma_bg_n === 1'b1 && link.main_bgack_n === 1'b1, "dma handshake stuck");
	endtask : t_dma

	// main sequence, mid-run reset included
	initial
	begin
		fails = 0;
		checked = 0;
		i_resetn = 1'b0;
		main_start = 1'b0;
		page_fault = 1'b0;
		genuine_error = 1'b0;
		dma_req = 1'b0;
		t_reset(20);
		t_normal();
		t_page_fault();
		t_genuine();
		t_dma();
		t_reset(3);
		t_page_fault();
		stop_test();
	end
endmodule : test_dual_master_fault_switch
`default_nettype wire
